// ### logic/aru_pkg.sv
`default_nettype none
package aru_pkg;

   // Accumulator width and the bit positions that the rotates wrap through.
   localparam int ACC_W = 8;
   localparam int ACC_MSB = 7;
   localparam int ACC_LSB = 0;
   localparam int OTHER_FLAGS_W = 7;

   // Reset values of the accumulator and the status flags.
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic CY_RESET = 1'h0;
   localparam logic [6:0] OTHER_RESET = 7'h00;

   // Every rotate finishes in one instruction cycle.
   localparam int EXEC_CYCLES = 1;

   // Operation selected by the instruction decoder for this cycle.
   typedef enum logic [1:0]
   {
      ROT_IDLE,
      ROTATE_LEFT_VIA_CARRY_OP,
      ROTATE_RIGHT_OP,
      ROTATE_RIGHT_VIA_CARRY_OP
   } aru_op_t;

   // Status flags: carry on top, the rest held as one group.
   typedef struct packed
   {
      logic cy;
      logic [6:0] other;
   } aru_flags_t;

   // One decoded instruction from the decoder.
   typedef struct packed
   {
      logic valid;
      aru_op_t op;
   } aru_cmd_t;

   // A write of accumulator and flags by the rest of the core.
   typedef struct packed
   {
      logic valid;
      logic [7:0] acc;
      aru_flags_t flags;
   } aru_load_t;

endpackage
`default_nettype wire

// ### logic/aru_rotate_core.sv
`timescale 1ns/10ps
`default_nettype none
module aru_rotate_core
   import aru_pkg::*;
#(
   parameter int WIDTH = ACC_W
)
(
   // Operation and operands.
   input wire aru_op_t i_op,
   input wire logic [WIDTH-1:0] i_acc,
   input wire logic i_cy,
   // Results.
   output logic [WIDTH-1:0] o_acc,
   output logic o_cy
);

   // Only the bits that a neighbour feeds; the end bits come from the case below.
   logic [WIDTH-1:1] shl;
   logic [WIDTH-2:0] shr;

   // Each bit takes its neighbour; the end bits are filled below.
   genvar b;
   generate
      for (b = 0; b < WIDTH - 1; b++)
      begin : g_bit
         assign shl[b + 1] = i_acc[b]; // see RULE1
         assign shr[b] = i_acc[b + 1]; // see RULE5
      end
   endgenerate

   // The end bits depend on the operation: wrap or take the carry.
   always_comb
   begin
      o_acc = i_acc;
      o_cy = i_cy;
      unique case (i_op)
         ROT_IDLE:
         begin
            o_acc = i_acc;
         end
         ROTATE_LEFT_VIA_CARRY_OP:
         begin
            o_acc = {shl[WIDTH-1:1], i_cy}; // see RULE3
            o_cy = i_acc[WIDTH-1]; // see RULE2
         end
         ROTATE_RIGHT_OP:
         begin
            o_acc = {i_acc[ACC_LSB], shr[WIDTH-2:0]}; // see RULE5
            o_cy = i_cy; // see RULE6
         end
         ROTATE_RIGHT_VIA_CARRY_OP:
         begin
            o_acc = {i_cy, shr[WIDTH-2:0]}; // see RULE8
            o_cy = i_acc[ACC_LSB]; // see RULE7
         end
      endcase
   end

endmodule
`default_nettype wire

// ### logic/aru_top.sv
// How it works
// RULE1 - Left-through-carry shifts accumulator up one bit; bit n takes old bit n-1.
// RULE2 - Left-through-carry loads the old accumulator top bit into carry.
// RULE3 - Left-through-carry puts the old carry into accumulator bit 0.
// RULE4 - Left-through-carry leaves all flags except carry unchanged.
// RULE5 - Plain rotate right shifts down; old bit 0 wraps into bit 7.
// RULE6 - Plain rotate right changes no flag, carry included.
// RULE7 - Right-through-carry shifts down and loads old bit 0 into carry.
// RULE8 - Right-through-carry puts the old carry into accumulator bit 7.
// RULE9 - Right-through-carry leaves all flags except carry unchanged.
// RULE10 - Each rotate completes in one cycle; the next instruction sees its result.
`timescale 1ns/10ps
`default_nettype none
module aru_top
   import aru_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_CE,
   // Decoded instruction and accumulator write from the core.
   input wire aru_cmd_t I_CMD,
   input wire aru_load_t I_LOAD,
   // Architectural state and completion strobe.
   output logic [ACC_W-1:0] O_ACC,
   output aru_flags_t O_FLAGS,
   output logic O_DONE
);

   logic exec;
   logic [ACC_W-1:0] next_acc;
   logic next_cy;
   logic cy;
   logic [OTHER_FLAGS_W-1:0] other_flags;

   // Carry and the other flags live in their own flops and leave as one word.
   assign O_FLAGS = {cy, other_flags};

   // A rotate is taken when enabled and a real operation is decoded.
   // It beats a simultaneous load, since both would target the accumulator.
   assign exec = I_CE && I_CMD.valid && (I_CMD.op != ROT_IDLE);

   // The rotate network works on the current accumulator and carry.
   aru_rotate_core #(
      .WIDTH(ACC_W)
   ) u_core (
      .i_op(I_CMD.op),
      .i_acc(O_ACC),
      .i_cy(O_FLAGS.cy),
      .o_acc(next_acc),
      .o_cy(next_cy)
   );

   // Accumulator: rotated result in the same cycle, or a core load.
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_ACC <= ACC_RESET;
      end
      else if (exec)
      begin
         O_ACC <= next_acc; // see RULE10
      end
      else if (I_CE && I_LOAD.valid)
      begin
         O_ACC <= I_LOAD.acc;
      end
   end

   // Carry: of the rotates only the through-carry ones change it; a core load also does.
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         cy <= CY_RESET;
      end
      else if (exec)
      begin
         cy <= next_cy; // see RULE6
      end
      else if (I_CE && I_LOAD.valid)
      begin
         cy <= I_LOAD.flags.cy;
      end
   end

   // Other flags: no rotate touches them, only a core load does.
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         other_flags <= OTHER_RESET;
      end
      else if (I_CE && I_LOAD.valid && !exec)
      begin
         other_flags <= I_LOAD.flags.other; // see RULE4 and RULE9
      end
   end

   // Completion strobe: one cycle after the rotate is taken.
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_DONE <= 1'h0;
      end
      else if (I_CE)
      begin
         O_DONE <= exec; // see RULE10
      end
   end

   // Checks on the left-through-carry result.
   rlc_shift_a: assert property ( // see RULE1
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_LEFT_VIA_CARRY_OP)
      |=> O_ACC[7:1] == $past(O_ACC[6:0]))
      else $error("Left rotate through carry did not shift the accumulator up.");

   rlc_carry_out_a: assert property ( // see RULE2
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_LEFT_VIA_CARRY_OP)
      |=> O_FLAGS.cy == $past(O_ACC[7]))
      else $error("Left rotate through carry lost the top bit.");

   rlc_carry_in_a: assert property ( // see RULE3
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_LEFT_VIA_CARRY_OP)
      |=> O_ACC[0] == $past(O_FLAGS.cy))
      else $error("Left rotate through carry did not fill bit 0 from carry.");

   rlc_flags_kept_a: assert property ( // see RULE4
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_LEFT_VIA_CARRY_OP)
      |=> $stable(O_FLAGS.other))
      else $error("Left rotate through carry changed another flag.");

   // Checks on the plain right rotate.
   rr_wrap_a: assert property ( // see RULE5
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_OP)
      |=> O_ACC == {$past(O_ACC[0]), $past(O_ACC[7:1])})
      else $error("Plain right rotate gave the wrong accumulator.");

   rr_flags_kept_a: assert property ( // see RULE6
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_OP)
      |=> $stable(O_FLAGS))
      else $error("Plain right rotate changed a flag.");

   // Checks on the right-through-carry result.
   rrc_carry_out_a: assert property ( // see RULE7
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_VIA_CARRY_OP)
      |=> O_FLAGS.cy == $past(O_ACC[0]) && O_ACC[6:0] == $past(O_ACC[7:1]))
      else $error("Right rotate through carry lost bit 0 or misshifted.");

   rrc_carry_in_a: assert property ( // see RULE8
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_VIA_CARRY_OP)
      |=> O_ACC[7] == $past(O_FLAGS.cy))
      else $error("Right rotate through carry did not fill bit 7 from carry.");

   rrc_flags_kept_a: assert property ( // see RULE9
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_VIA_CARRY_OP)
      |=> $stable(O_FLAGS.other))
      else $error("Right rotate through carry changed another flag.");

   // Timing: strobe one cycle later, and a follow-on rotate sees the result.
   rot_one_cycle_a: assert property ( // see RULE10
      @(posedge I_CLK) disable iff (!I_RESET_N)
      exec |=> O_DONE)
      else $error("Rotate did not complete in one cycle.");

   rot_chain_a: assert property ( // see RULE10
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_OP) ##1
      (exec && I_CMD.op == ROTATE_RIGHT_OP)
      |=> O_ACC == {$past(O_ACC[1:0], 2), $past(O_ACC[7:2], 2)})
      else $error("Back-to-back rotates did not chain.");

   ce_freeze_a: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      !I_CE |=> $stable(O_ACC) && $stable(O_FLAGS) && $stable(O_DONE))
      else $error("State moved while the clock enable was low.");

   // The through-carry rotates seen as one nine-bit rotate.
   rlc_nine_bit_a: assert property ( // see RULE1
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_LEFT_VIA_CARRY_OP)
      |=> {O_FLAGS.cy, O_ACC} == {$past(O_ACC), $past(O_FLAGS.cy)})
      else $error("Left rotate through carry gave the wrong nine-bit result.");

   rrc_nine_bit_a: assert property ( // see RULE7
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_CMD.op == ROTATE_RIGHT_VIA_CARRY_OP)
      |=> {O_ACC, O_FLAGS.cy} == {$past(O_FLAGS.cy), $past(O_ACC)})
      else $error("Right rotate through carry gave the wrong nine-bit result.");

   // Loads, idle cycles and the completion strobe.
   load_take_a: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && I_LOAD.valid && !exec)
      |=> O_ACC == $past(I_LOAD.acc) && O_FLAGS == $past(I_LOAD.flags))
      else $error("A load without a rotate was not taken.");

   load_drop_a: assert property ( // see RULE4
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (exec && I_LOAD.valid)
      |=> $stable(O_FLAGS.other))
      else $error("A load beside a rotate changed the other flags.");

   idle_hold_a: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && !exec && !I_LOAD.valid)
      |=> $stable(O_ACC) && $stable(O_FLAGS))
      else $error("State moved in a cycle with no rotate and no load.");

   done_clear_a: assert property ( // see RULE10
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CE && !exec) |=> !O_DONE)
      else $error("Completion strobe stood without a rotate.");

endmodule
`default_nettype wire

// ### tb/aru_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module aru_top_bench;
   import aru_pkg::*;

   // One ordinary case: loaded state, operation, expected state.
   typedef struct packed
   {
      logic [7:0] acc;
      logic [7:0] flg;
      aru_op_t op;
      logic [7:0] x_acc;
      logic [7:0] x_flg;
   } aru_row_t;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   aru_cmd_t cmd = '0;
   aru_load_t ld = '0;
   logic [7:0] acc;
   aru_flags_t flags;
   logic done;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   aru_row_t rows [9];

   // The unit under test.
   aru_top u_aru_top (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_CMD(cmd), .I_LOAD(ld),
      .O_ACC(acc), .O_FLAGS(flags), .O_DONE(done));

   // The core clock at 25 MHz.
   always #20 clk = ~clk;

   // Compares an eight-bit result.
   task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Compares a one-bit result.
   task automatic cmp1(input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Holds the inputs for one clock edge, starting and ending at a falling edge.
   task automatic cyc(input aru_cmd_t c, input aru_load_t l);
      if (cmd !== c)
         cmd = c;
      if (ld !== l)
         ld = l;
      @(negedge clk);
   endtask

   // Loads accumulator and flags, then leaves the ports idle.
   task automatic load(input logic [7:0] a, input logic [7:0] f);
      cyc('0, {1'b1, a, aru_flags_t'(f)});
      ld = '0;
   endtask

   // Checks the whole visible state.
   task automatic state(input logic [7:0] a, input logic [7:0] f, input logic d);
      cmp8(a, acc);
      cmp8(f, flags);
      cmp1(d, done);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected 33 cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= 2000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   initial
   begin
      rows[0] = {8'hc5, 8'h00, ROTATE_LEFT_VIA_CARRY_OP, 8'h8a, 8'h80};
      rows[1] = {8'h45, 8'h80, ROTATE_LEFT_VIA_CARRY_OP, 8'h8b, 8'h00};
      rows[2] = {8'hbc, 8'h7f, ROTATE_LEFT_VIA_CARRY_OP, 8'h78, 8'hff};
      rows[3] = {8'hc5, 8'h00, ROTATE_RIGHT_OP, 8'he2, 8'h00};
      rows[4] = {8'hc5, 8'hff, ROTATE_RIGHT_OP, 8'he2, 8'hff};
      rows[5] = {8'h3a, 8'h80, ROTATE_RIGHT_OP, 8'h1d, 8'h80};
      rows[6] = {8'hc5, 8'h00, ROTATE_RIGHT_VIA_CARRY_OP, 8'h62, 8'h80};
      rows[7] = {8'h4a, 8'h80, ROTATE_RIGHT_VIA_CARRY_OP, 8'ha5, 8'h00};
      rows[8] = {8'h01, 8'h7f, ROTATE_RIGHT_VIA_CARRY_OP, 8'h00, 8'hff};
      // Reset: state is cleared while reset is held.
      repeat (2) @(negedge clk);
      state(8'h00, 8'h00, 1'b0);
      rst_n = 1'b1;
      @(negedge clk);
      $display("test reset done");
      // Ordinary cases: one load, one rotate, result seen one cycle later.
      foreach (rows[i])
      begin
         load(rows[i].acc, rows[i].flg);
         state(rows[i].acc, rows[i].flg, 1'b0);
         cyc({1'b1, rows[i].op}, '0);
         cmd = '0;
         state(rows[i].x_acc, rows[i].x_flg, 1'b1);
      end
      $display("test table done");
      // Back to back rotates each see the result of the one before.
      load(8'h81, 8'h00);
      cyc({1'b1, ROTATE_LEFT_VIA_CARRY_OP}, '0);
      state(8'h02, 8'h80, 1'b1);
      cyc({1'b1, ROTATE_RIGHT_VIA_CARRY_OP}, '0);
      state(8'h81, 8'h00, 1'b1);
      cyc({1'b1, ROTATE_RIGHT_OP}, '0);
      state(8'hc0, 8'h00, 1'b1);
      cyc({1'b1, ROTATE_RIGHT_OP}, '0);
      state(8'h60, 8'h00, 1'b1);
      $display("test back to back done");
      // A load in the same cycle as a rotate is dropped.
      cyc({1'b1, ROTATE_LEFT_VIA_CARRY_OP}, {1'b1, 8'h5a, aru_flags_t'(8'h7f)});
      state(8'hc0, 8'h00, 1'b1);
      // With the clock enable low nothing is taken and the strobe stands.
      ce = 1'b0;
      cyc({1'b1, ROTATE_RIGHT_OP}, {1'b1, 8'h11, aru_flags_t'(8'h00)});
      state(8'hc0, 8'h00, 1'b1);
      ce = 1'b1;
      // A valid idle command is a no-op and ends the strobe.
      cyc({1'b1, ROT_IDLE}, '0);
      state(8'hc0, 8'h00, 1'b0);
      $display("test refusals done");
      // A second reset in mid-run clears the state at once.
      load(8'ha5, 8'hff);
      #5 rst_n = 1'b0;
      #5 state(8'h00, 8'h00, 1'b0);
      @(negedge clk);
      state(8'h00, 8'h00, 1'b0);
      rst_n = 1'b1;
      // The first edge after release already takes a load.
      load(8'h03, 8'h80);
      state(8'h03, 8'h80, 1'b0);
      cyc({1'b1, ROTATE_RIGHT_VIA_CARRY_OP}, '0);
      cmd = '0;
      state(8'h81, 8'h80, 1'b1);
      $display("test second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
